// ==== rpds_device.sv ====
// Device end: sequences the core through reset, power-down and start-up
// What this block does
// - Reset forces power-stage output low after 300 ns
// - Controller holds reset low about 1 ms
// - Control port opens 3.5 ms after reset release
// - Run only 10 ms after start-up command
// - Power-down drives power-stage output low after 725 us
// - Controller holds power-down low at least 800 ns
// - Control port works without the audio clock
`timescale 1ns/1ps
`default_nettype none
module rpds_device #(
	parameter int RST_LOW_CYC = rpds_pkg::RST_VALID_LOW_CYC,
	parameter int READY_CYC = rpds_pkg::CTRL_READY_CYC,
	parameter int RUN_CYC = rpds_pkg::RUN_MIN_CYC,
	parameter int PDN_LOW_CYC = rpds_pkg::PDN_VALID_LOW_CYC
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	rpds_if.device lnk,
	output logic o_running,
	output logic o_port_ready
);
	import rpds_pkg::*;
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	// Separate drop counter, since a reset may land in the middle of a power-down drop
	rpds_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] dly_q, dly_d;
	logic valid_q, valid_d;
	logic ready_q, ready_d;
	logic rst_act, pdn_act;
	logic port_done, run_done, down_done, rst_done;
	logic cmd_take;
	// ----------------------------------------
	// Input decode
	// ----------------------------------------
	// Both inputs are active low
	assign rst_act = !lnk.reset_n;
	assign pdn_act = !lnk.power_down_in_n;
	// Counts start at zero, so each end point is one below its figure
	assign port_done = (cnt_q >= CNT_W'(READY_CYC - 1));
	assign run_done = (cnt_q >= CNT_W'(RUN_CYC - 1));
	assign down_done = (dly_q >= CNT_W'(PDN_LOW_CYC - 1));
	assign rst_done = (dly_q >= CNT_W'(RST_LOW_CYC - 1));
	// Commands are only heard with the port open and power-down released
	assign cmd_take = (state_q == RPDS_ST_IDLE) && lnk.startup_cmd && !pdn_act;
	// ----------------------------------------
	// Sequence state and interval counter
	// ----------------------------------------
	// Runs from i_clk alone, so the port never waits on an audio clock
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (rst_act) begin
			state_d = RPDS_ST_RESET;
			cnt_d = '0;
		end else begin
			case (state_q)
				RPDS_ST_RESET: begin
					cnt_d = '0;
					state_d = RPDS_ST_WAIT_PORT;
				end
				RPDS_ST_WAIT_PORT: begin
					// Commands before this point are ignored
					if (port_done) begin
						cnt_d = '0;
						state_d = RPDS_ST_IDLE;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				RPDS_ST_IDLE: begin
					if (cmd_take) begin
						cnt_d = '0;
						state_d = RPDS_ST_STARTUP;
					end
				end
				RPDS_ST_STARTUP: begin
					// Power-down here abandons the start-up; a new command is needed
					if (pdn_act) begin
						state_d = RPDS_ST_IDLE;
					end else if (run_done) begin
						state_d = RPDS_ST_RUN;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				RPDS_ST_RUN: begin
					if (pdn_act) begin
						state_d = RPDS_ST_DOWN;
					end
				end
				RPDS_ST_DOWN: begin
					// Release during the count does not cancel the drop
					if (down_done) begin
						state_d = RPDS_ST_IDLE;
					end
				end
				default: begin
					state_d = RPDS_ST_RESET;
					cnt_d = '0;
				end
			endcase
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_q <= RPDS_ST_RESET;
			cnt_q <= '0;
		end else if (i_ce) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end
	// ----------------------------------------
	// Power-stage control and its drop delay
	// ----------------------------------------
	// Low until start-up completes; drops after a counted delay, or at once in the reset state once a short reset is released
	always_comb begin
		valid_d = valid_q;
		dly_d = dly_q;
		// A reset shorter than the delay still drops the stage via the reset state
		if (rst_act) begin
			if (valid_q) begin
				if (rst_done) begin
					valid_d = 1'b0;
					dly_d = '0;
				end else begin
					dly_d = dly_q + 1'b1;
				end
			end else begin
				dly_d = '0;
			end
		end else begin
			case (state_q)
				RPDS_ST_STARTUP: begin
					if (!pdn_act && run_done) begin
						valid_d = 1'b1;
					end
				end
				RPDS_ST_RUN: begin
					dly_d = '0;
				end
				RPDS_ST_DOWN: begin
					if (down_done) begin
						valid_d = 1'b0;
						dly_d = '0;
					end else begin
						dly_d = dly_q + 1'b1;
					end
				end
				RPDS_ST_RESET: begin
					valid_d = 1'b0;
					dly_d = '0;
				end
				RPDS_ST_WAIT_PORT, RPDS_ST_IDLE: begin
					valid_d = 1'b0;
					dly_d = '0;
				end
				default: begin
					valid_d = 1'b0;
					dly_d = '0;
				end
			endcase
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			valid_q <= 1'b0;
			dly_q <= '0;
		end else if (i_ce) begin
			valid_q <= valid_d;
			dly_q <= dly_d;
		end
	end
	// ----------------------------------------
	// Control port open flag
	// ----------------------------------------
	// Cleared on every reset so a late command is never taken
	always_comb begin
		ready_d = ready_q;
		if (rst_act) begin
			ready_d = 1'b0;
		end else if ((state_q == RPDS_ST_WAIT_PORT) && port_done) begin
			ready_d = 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			ready_q <= 1'b0;
		end else if (i_ce) begin
			ready_q <= ready_d;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Link and pin copies come from the same flops, so they always agree
	assign lnk.stage_valid = valid_q;
	assign lnk.port_ready = ready_q;
	assign o_running = valid_q;
	assign o_port_ready = ready_q;
endmodule
`default_nettype wire

// ==== rpds_pkg.sv ====
// Package of timing constants and states for the reset and power-down sequencer
package rpds_pkg;
	// ----------------------------------------
	// Clock
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// ----------------------------------------
	// Printed times in their own units
	// ----------------------------------------
	localparam int RST_VALID_LOW_NS = 300;
	localparam int RST_PULSE_MS = 1;
	localparam int CTRL_READY_US = 3500;
	localparam int RUN_MIN_MS = 10;
	localparam int PDN_VALID_LOW_US = 725;
	localparam int PDN_PULSE_NS = 800;
	// ----------------------------------------
	// Derived cycle counts
	// ----------------------------------------
	localparam int RST_VALID_LOW_CYC = RST_VALID_LOW_NS / CLK_PERIOD_NS;
	localparam int RST_PULSE_CYC = (RST_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CTRL_READY_CYC = CTRL_READY_US * 1000 / CLK_PERIOD_NS;
	localparam int RUN_MIN_CYC = (RUN_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PDN_VALID_LOW_CYC = PDN_VALID_LOW_US * 1000 / CLK_PERIOD_NS;
	localparam int PDN_PULSE_CYC = (PDN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 24;
	// ----------------------------------------
	// Device states, Gray along the usual path
	// ----------------------------------------
	typedef enum logic [2:0] {
		RPDS_ST_RESET = 3'h0,
		RPDS_ST_WAIT_PORT = 3'h1,
		RPDS_ST_IDLE = 3'h3,
		RPDS_ST_STARTUP = 3'h2,
		RPDS_ST_RUN = 3'h6,
		RPDS_ST_DOWN = 3'h7
	} rpds_state_t;
	typedef enum logic [2:0] {
		RPDS_H_RESET = 3'h0,
		RPDS_H_WAIT_PORT = 3'h1,
		RPDS_H_CMD = 3'h3,
		RPDS_H_WAIT_RUN = 3'h2,
		RPDS_H_RUN = 3'h6,
		RPDS_H_PDN = 3'h7
	} rpds_host_state_t;
endpackage

// ==== rpds_if.sv ====
// Interface joining the device and controller ends of the sequencer link
`timescale 1ns/1ps
`default_nettype none
interface rpds_if;
	logic reset_n;
	logic power_down_in_n;
	logic startup_cmd;
	logic port_ready;
	logic stage_valid;
	modport device (
		input reset_n,
		input power_down_in_n,
		input startup_cmd,
		output port_ready,
		output stage_valid
	);
	modport host (
		output reset_n,
		output power_down_in_n,
		output startup_cmd,
		input port_ready,
		input stage_valid
	);
endinterface
`default_nettype wire

// ==== rpds_host.sv ====
// Controller end: drives reset, power-down and start-up command
`timescale 1ns/1ps
`default_nettype none
module rpds_host #(
	parameter int RST_CYC = rpds_pkg::RST_PULSE_CYC,
	parameter int READY_CYC = rpds_pkg::CTRL_READY_CYC,
	parameter int RUN_CYC = rpds_pkg::RUN_MIN_CYC,
	parameter int PDN_CYC = rpds_pkg::PDN_PULSE_CYC
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic i_power_down,
	rpds_if.host lnk,
	output logic o_busy,
	output logic o_running
);
	import rpds_pkg::*;
	// ----------------------------------------
	// State
	// ----------------------------------------
	rpds_host_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic rstn_q, rstn_d;
	logic pdn_n_q, pdn_n_d;
	logic cmd_q, cmd_d;
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		rstn_d = rstn_q;
		pdn_n_d = pdn_n_q;
		cmd_d = 1'b0;
		case (state_q)
			RPDS_H_RESET: begin
				// Hold reset low for the full pulse
				rstn_d = 1'b0;
				if (cnt_q >= CNT_W'(RST_CYC - 1)) begin
					rstn_d = 1'b1;
					cnt_d = '0;
					state_d = RPDS_H_WAIT_PORT;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			RPDS_H_WAIT_PORT: begin
				// No commands until the port is open
				if (cnt_q >= CNT_W'(READY_CYC) && lnk.port_ready) begin
					cnt_d = '0;
					state_d = RPDS_H_CMD;
				end else if (cnt_q < CNT_W'(READY_CYC)) begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			RPDS_H_CMD: begin
				if (i_start) begin
					cmd_d = 1'b1;
					cnt_d = '0;
					state_d = RPDS_H_WAIT_RUN;
				end
			end
			RPDS_H_WAIT_RUN: begin
				// Allow the start-up interval before expecting run
				// Power-down may still abandon a start-up in progress
				if (i_power_down) begin
					pdn_n_d = 1'b0;
					cnt_d = '0;
					state_d = RPDS_H_PDN;
				end else if (cnt_q >= CNT_W'(RUN_CYC)) begin
					state_d = RPDS_H_RUN;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			RPDS_H_RUN: begin
				if (i_power_down) begin
					pdn_n_d = 1'b0;
					cnt_d = '0;
					state_d = RPDS_H_PDN;
				end
			end
			RPDS_H_PDN: begin
				// Keep power-down low at least the minimum pulse
				if (cnt_q >= CNT_W'(PDN_CYC - 1) && !i_power_down) begin
					pdn_n_d = 1'b1;
					state_d = RPDS_H_CMD;
				end else if (cnt_q < CNT_W'(PDN_CYC - 1)) begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			default: begin
				state_d = RPDS_H_RESET;
				cnt_d = '0;
			end
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_q <= RPDS_H_RESET;
			cnt_q <= '0;
			rstn_q <= 1'b0;
			pdn_n_q <= 1'b1;
			cmd_q <= 1'b0;
		end else if (i_ce) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			rstn_q <= rstn_d;
			pdn_n_q <= pdn_n_d;
			cmd_q <= cmd_d;
		end
	end
	assign lnk.reset_n = rstn_q;
	assign lnk.power_down_in_n = pdn_n_q;
	assign lnk.startup_cmd = cmd_q;
	assign o_busy = (state_q != RPDS_H_CMD) && (state_q != RPDS_H_RUN);
	assign o_running = (state_q == RPDS_H_RUN) && lnk.stage_valid;
endmodule
`default_nettype wire

// ==== rpds_checker.sv ====
// Checker of the timing on the sequencer link
`timescale 1ns/1ps
`default_nettype none
module rpds_checker #(
	parameter int RST_LOW_CYC = 6,
	parameter int READY_CYC = 8,
	parameter int RUN_CYC = 12,
	parameter int PDN_LOW_CYC = 10,
	parameter int RST_CYC = 5,
	parameter int PDN_CYC = 4
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic reset_n,
	input wire logic power_down_in_n,
	input wire logic startup_cmd,
	input wire logic port_ready,
	input wire logic stage_valid
);
	localparam int RL1 = RST_LOW_CYC + 2;
	localparam int RD0 = READY_CYC;
	localparam int RD1 = READY_CYC + 3;
	localparam int PL1 = PDN_LOW_CYC + 2;
	// --------
	// Counters
	// --------
	// Plain ints: the run is far too short for them to wrap
	int lo_q = 0;
	int run_q = 1 << 20;
	int pd_q = 1 << 20;
	always_ff @(posedge i_clk) begin
		lo_q <= reset_n ? 0 : lo_q + 1;
		run_q <= startup_cmd ? 0 : run_q + 1;
		pd_q <= $fell(power_down_in_n) ? 0 : pd_q + 1;
	end
	// --------
	// Properties
	// --------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_rst_seen;
		$fell(reset_n);
	endsequence
	sequence s_pdn_seen;
		$fell(power_down_in_n) && stage_valid;
	endsequence
	property p_rst_low; s_rst_seen |-> ##[1:RL1] !stage_valid; endproperty
	a_rst_low: assert property (p_rst_low) else $error("stage late after reset");
	property p_rst_pulse; $rose(reset_n) |-> lo_q >= RST_CYC - 1; endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short");
	property p_port_open; $rose(reset_n) |-> ##[RD0:RD1] $rose(port_ready); endproperty
	a_port_open: assert property (p_port_open) else $error("port open time");
	property p_cmd_gate; startup_cmd |-> port_ready && power_down_in_n; endproperty
	a_cmd_gate: assert property (p_cmd_gate) else $error("command while closed");
	property p_run_time; $rose(stage_valid) |-> run_q inside {[RUN_CYC - 1:RUN_CYC + 2]}; endproperty
	a_run_time: assert property (p_run_time) else $error("start-up time");
	property p_pdn_low; s_pdn_seen |-> ##[1:PL1] !stage_valid; endproperty
	a_pdn_low: assert property (p_pdn_low) else $error("stage late after power-down");
	property p_pdn_pulse; $rose(power_down_in_n) |-> pd_q >= PDN_CYC - 1; endproperty
	a_pdn_pulse: assert property (p_pdn_pulse) else $error("power-down pulse short");
	property p_rise_ok; $rose(stage_valid) |-> reset_n && power_down_in_n; endproperty
	a_rise_ok: assert property (p_rise_ok) else $error("stage up while held");
endmodule
`default_nettype wire

// ==== rpds_tb.sv ====
// Testbench driving both sequencer ends through reset, start-up and power-down
`timescale 1ns/1ps
`default_nettype none
module rpds_tb;
	localparam int RL = 6;
	localparam int RD = 8;
	localparam int RN = 12;
	localparam int PL = 10;
	localparam int RC = 10;
	localparam int PC = 4;
	logic clk = 1'h0;
	logic rstn_d = 1'h0;
	logic rstn_h = 1'h0;
	logic start = 1'h0;
	logic pdown = 1'h0;
	logic d_run, d_rdy, h_busy, h_run;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	rpds_if u_rpds_if ();
	rpds_device #(.RST_LOW_CYC(RL), .READY_CYC(RD), .RUN_CYC(RN), .PDN_LOW_CYC(PL)) u_rpds_device (
		.i_clk(clk), .i_resetn(rstn_d), .i_ce(1'h1), .lnk(u_rpds_if.device),
		.o_running(d_run), .o_port_ready(d_rdy));
	rpds_host #(.RST_CYC(RC), .READY_CYC(RD), .RUN_CYC(RN), .PDN_CYC(PC)) u_rpds_host (
		.i_clk(clk), .i_resetn(rstn_h), .i_ce(1'h1), .i_start(start), .i_power_down(pdown),
		.lnk(u_rpds_if.host), .o_busy(h_busy), .o_running(h_run));
	rpds_checker #(.RST_LOW_CYC(RL), .READY_CYC(RD), .RUN_CYC(RN), .PDN_LOW_CYC(PL),
		.RST_CYC(RC), .PDN_CYC(PC)) u_chk (.i_clk(clk), .i_resetn(rstn_d),
		.reset_n(u_rpds_if.reset_n), .power_down_in_n(u_rpds_if.power_down_in_n),
		.startup_cmd(u_rpds_if.startup_cmd), .port_ready(u_rpds_if.port_ready),
		.stage_valid(u_rpds_if.stage_valid));
	always #5 clk = ~clk;
	// --------
	// Tasks
	// --------
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Bounded so that a dead link still ends the run
	task automatic wait_sig(input int sel, input logic lvl);
		logic v;
		n = 0;
		do begin
			tick(1);
			n++;
			case (sel)
				0: v = u_rpds_if.port_ready;
				1: v = u_rpds_if.stage_valid;
				default: v = u_rpds_if.startup_cmd;
			endcase
		end while (v !== lvl && n < 500);
	endtask
	task automatic send_cmd();
		start = 1'h1;
		wait_sig(2, 1'h1);
		start = 1'h0;
	endtask
	task automatic run_up(input logic abort);
		send_cmd();
		if (abort) begin
			pdown = 1'h1;
			tick(1);
			pdown = 1'h0;
			tick(RN + 6);
			chk("abort", u_rpds_if.stage_valid, 1'h0);
			send_cmd();
		end
		wait_sig(1, 1'h1);
		chk("t_run", n inside {[RN:RN + 3]}, 1'h1);
		chk("run", {h_run, d_run}, 2'h3);
		chk("busy_run", h_busy, 1'h0);
	endtask
	task automatic stop_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// --------
	// Scenarios
	// --------
	initial begin
		tick(10);
		rstn_d = 1'h1;
		rstn_h = 1'h1;
		chk("valid_rst", u_rpds_if.stage_valid, 1'h0);
		chk("busy_rst", h_busy, 1'h1);
		wait_sig(0, 1'h1);
		chk("t_ready", n inside {[RC + RD:RC + RD + 4]}, 1'h1);
		run_up(1'h1);
		pdown = 1'h1;
		tick(1);
		pdown = 1'h0;
		wait_sig(1, 1'h0);
		chk("t_pdn", n inside {[PL:PL + 4]}, 1'h1);
		chk("rdy_pdn", d_rdy, 1'h1);
		run_up(1'h0);
		rstn_h = 1'h0;
		tick(1);
		rstn_h = 1'h1;
		wait_sig(1, 1'h0);
		chk("t_rst", n inside {[RL:RL + 3]}, 1'h1);
		chk("rdy_rst", u_rpds_if.port_ready, 1'h0);
		wait_sig(0, 1'h1);
		chk("reopen", n < RC + RD + 4, 1'h1);
		run_up(1'h0);
		stop_test();
	end
	initial begin
		#100000;
		err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
